// >>> core/bridge_ctl_defines.vh
`ifndef BRIDGE_CTL_DEFINES_VH
`define BRIDGE_CTL_DEFINES_VH
`define OFS_ARB_CHIP 12'h040
`define OFS_EXT_OPTS 12'h048
`define OFS_PREEMPT 12'h04C
`define OFS_SERR_MASK 12'h064
`define OFS_CLK_STAT 12'h068
`define OFS_CLOCK_STOP_CONTROL 12'h06C
`define BIT_WR_LIMIT 12
`define BIT_BRIDGE_PRIO 25
`define RST_PRIO 5'h1_0
`define RST_CLK_RSVD 5'h1F
`define PREEMPT_LOG_MAX 3
`endif

// >>> core/bridge_device_specific_control.v
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bridge_ctl_defines.vh"
// device-specific control bank: options, arbiter, error reporting, clock gating
module bridge_device_specific_control #(
   parameter NREQ = 4
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire serr_enable,
   input wire [7:0] serr_event,
   input wire [NREQ-1:0] sec_req,
   input wire bridge_req,
   input wire sec_frame,
   input wire sec_bus_idle,
   input wire pri_stop_req,
   output reg [NREQ-1:0] sec_gnt_r,
   output reg bridge_gnt_r,
   output reg primary_system_error_n,
   output reg [4:0] slot_clock_output,
   output reg sec_clock_stopped_r,
   output wire pri_clock_run_req,
   output wire sec_clock_stop_control_en,
   output wire pri_clock_stop_control_en,
   output wire posted_write_limit_two,
   output wire read_flow_through_en,
   output wire down_prefetch_dyn_en,
   output wire up_prefetch_dyn_en,
   output wire read_wait_cache_line
);
   reg wr_limit_r;
   reg [NREQ-1:0] req_prio_r;
   reg bridge_master_priority;
   reg [4:0] ext_opts_r;
   reg [3:0] preempt_code_r;
   reg [5:0] serr_mask_r;
   reg [8:0] slot_gate_r;
   reg [3:0] clock_stop_control_r;
   reg last_owner_bridge_r;
   reg [NREQ-1:0] last_owner_r;
   reg frame_d_r;
   wire [7:0] cause;
   wire wr_en;
   wire rd_en;
   wire hit;
   wire [7:0] evt_gated;
   wire any_serr;
   wire preempt_exp;
   wire frame_start;
   wire owner_active;
   wire [NREQ-1:0] hi_req;
   wire [NREQ-1:0] lo_req;
   wire any_req;
   wire stop_cond;
   genvar g;

   // bus decode; zero-wait-state slave
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   assign hit = (paddr == `OFS_ARB_CHIP) | (paddr == `OFS_EXT_OPTS) |
                (paddr == `OFS_PREEMPT) | (paddr == `OFS_SERR_MASK) |
                (paddr == `OFS_CLK_STAT) | (paddr == `OFS_CLOCK_STOP_CONTROL);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // writable fields
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_limit_r <= 1'b0;
         req_prio_r <= {NREQ{1'b0}};
         bridge_master_priority <= 1'b1;
         ext_opts_r <= 5'h0_0;
         preempt_code_r <= 4'h0;
         serr_mask_r <= 6'h0_0;
         slot_gate_r <= 9'h0_00;
         clock_stop_control_r <= 4'h0;
      end else if (wr_en) begin
         case (paddr)
            `OFS_ARB_CHIP: begin
               if (pstrb[1]) wr_limit_r <= pwdata[`BIT_WR_LIMIT];
               if (pstrb[2]) req_prio_r <= pwdata[16+NREQ-1:16];
               if (pstrb[3]) bridge_master_priority <= pwdata[`BIT_BRIDGE_PRIO];
            end
            `OFS_EXT_OPTS: begin
               if (pstrb[0]) ext_opts_r <= pwdata[4:0];
            end
            `OFS_PREEMPT: begin
               if (pstrb[3]) preempt_code_r <= pwdata[31:28];
            end
            `OFS_SERR_MASK: begin
               if (pstrb[0]) serr_mask_r <= pwdata[6:1];
            end
            `OFS_CLK_STAT: begin
               if (pstrb[0]) slot_gate_r[7:0] <= pwdata[7:0];
               if (pstrb[1]) slot_gate_r[8] <= pwdata[8];
            end
            `OFS_CLOCK_STOP_CONTROL: begin
               if (pstrb[3]) clock_stop_control_r <= pwdata[28:25];
            end
            default: begin
            end
         endcase
      end
   end

   // option outputs
   assign posted_write_limit_two = wr_limit_r;
   assign read_flow_through_en = ext_opts_r[0];
   assign down_prefetch_dyn_en = ~ext_opts_r[2];
   assign up_prefetch_dyn_en = ~ext_opts_r[3];
   assign read_wait_cache_line = ext_opts_r[4];

   // event gating: cause bits 16..22 map events 0..6, 23 is master timeout
   assign evt_gated[0] = serr_event[0];
   assign evt_gated[7] = serr_event[7];
   generate
      for (g = 1; g < 7; g = g + 1) begin : g_mask
         assign evt_gated[g] = serr_event[g] & ~serr_mask_r[g-1];
      end
      for (g = 0; g < 8; g = g + 1) begin : g_cause
         serr_cause_bit u_bit (
            .pclk(pclk),
            .presetn(presetn),
            .set_evt(evt_gated[g] & serr_enable),
            .clr(wr_en & (paddr == `OFS_CLK_STAT) & pstrb[2] & pwdata[16+g]),
            .flag_r(cause[g])
         );
      end
   endgenerate
   assign any_serr = serr_enable & (|evt_gated);

   // system error pin, active low, asserted the cycle after an event
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_system_error_n <= 1'b1;
      end else begin
         primary_system_error_n <= ~any_serr;
      end
   end

   // clock-run control
   assign sec_clock_stop_control_en = clock_stop_control_r[0];
   assign pri_clock_stop_control_en = clock_stop_control_r[2];
   assign pri_clock_run_req = clock_stop_control_r[1] | ~sec_clock_stopped_r;
   assign stop_cond = clock_stop_control_r[3] ? (sec_bus_idle & ~pri_stop_req) : pri_stop_req;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_clock_stopped_r <= 1'b0;
      end else begin
         sec_clock_stopped_r <= clock_stop_control_r[0] & stop_cond;
      end
   end

   // slot clock enables, low when stopped by field or clock-run
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_clock_output <= 5'h1F;
      end else begin
         slot_clock_output[0] <= ~(&slot_gate_r[1:0]) & ~sec_clock_stopped_r;
         slot_clock_output[1] <= ~(&slot_gate_r[3:2]) & ~sec_clock_stopped_r;
         slot_clock_output[2] <= ~(&slot_gate_r[5:4]) & ~sec_clock_stopped_r;
         slot_clock_output[3] <= ~(&slot_gate_r[7:6]) & ~sec_clock_stopped_r;
         slot_clock_output[4] <= ~slot_gate_r[8] & ~sec_clock_stopped_r;
      end
   end

   // arbiter
   assign frame_start = sec_frame & ~frame_d_r;
   assign owner_active = (|sec_gnt_r) | bridge_gnt_r;
   preempt_timer u_preempt (
      .pclk(pclk),
      .presetn(presetn),
      .frame_start(frame_start),
      .bus_busy(sec_frame),
      .code(preempt_code_r),
      .expired(preempt_exp)
   );
   assign hi_req = sec_req & req_prio_r & ~sec_gnt_r;
   assign lo_req = sec_req & ~req_prio_r & ~sec_gnt_r;
   assign any_req = (|hi_req) | (|lo_req) | (bridge_req & ~bridge_gnt_r);

   // grant the lowest-numbered high requester, bridge by its group
   function [NREQ:0] pick;
      input [NREQ-1:0] hr;
      input [NREQ-1:0] lr;
      input br;
      input bhi;
      integer i;
      reg [NREQ-1:0] v;
      reg done;
      begin
         pick = {(NREQ+1){1'b0}};
         done = 1'b0;
         v = {NREQ{1'b0}};
         if (br & bhi) begin
            pick[NREQ] = 1'b1;
            done = 1'b1;
         end
         for (i = 0; i < NREQ; i = i + 1) begin
            if (!done && hr[i]) begin
               v[i] = 1'b1;
               done = 1'b1;
            end
         end
         if (!done && br) begin
            pick[NREQ] = 1'b1;
            done = 1'b1;
         end
         for (i = 0; i < NREQ; i = i + 1) begin
            if (!done && lr[i]) begin
               v[i] = 1'b1;
               done = 1'b1;
            end
         end
         pick[NREQ-1:0] = v;
      end
   endfunction

   // one arbitration result: secondary grants below, bridge grant on top
   wire [NREQ:0] next_owner;
   assign next_owner = pick(hi_req, lo_req, bridge_req, bridge_master_priority);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_gnt_r <= {NREQ{1'b0}};
         bridge_gnt_r <= 1'b0;
         last_owner_bridge_r <= 1'b0;
         last_owner_r <= {NREQ{1'b0}};
         frame_d_r <= 1'b0;
      end else begin
         frame_d_r <= sec_frame;
         if (owner_active && sec_frame && preempt_exp && any_req) begin
            sec_gnt_r <= {NREQ{1'b0}};
            bridge_gnt_r <= 1'b0;
         end else if (!sec_frame && any_req) begin
            {bridge_gnt_r, sec_gnt_r} <= next_owner;
            last_owner_r <= next_owner[NREQ-1:0];
            last_owner_bridge_r <= next_owner[NREQ];
         end else if (!sec_frame && !(|(sec_gnt_r & sec_req))) begin
            // idle bus, granted master no longer asking: park it
            if (ext_opts_r[1]) begin
               sec_gnt_r <= {NREQ{1'b0}};
               bridge_gnt_r <= 1'b1;
            end else if (!owner_active) begin
               sec_gnt_r <= last_owner_r;
               bridge_gnt_r <= last_owner_bridge_r;
            end
         end
      end
   end

   // read mux; reserved bits zero, except clock-status bits 13:9, which read as ones
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         case (paddr)
            `OFS_ARB_CHIP: prdata <= {6'h0_0, bridge_master_priority, 5'h0_0,
               {(4-NREQ){1'b0}}, req_prio_r, 3'h0, wr_limit_r, 12'h000};
            `OFS_EXT_OPTS: prdata <= {27'h000_0000, ext_opts_r};
            `OFS_PREEMPT: prdata <= {preempt_code_r, 28'h000_0000};
            `OFS_SERR_MASK: prdata <= {25'h000_0000, serr_mask_r, 1'b0};
            `OFS_CLK_STAT: prdata <= {8'h00, cause, 2'h0, `RST_CLK_RSVD, slot_gate_r};
            `OFS_CLOCK_STOP_CONTROL: prdata <= {3'h0, clock_stop_control_r, sec_clock_stopped_r, 24'h00_0000};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule // bridge_device_specific_control
`default_nettype wire

// >>> core/preempt_timer.v
`timescale 1ns/1ps
`default_nettype none
// counts clocks from frame start and flags when the preemption delay is reached
module preempt_timer #(
   parameter CW = 7
) (
   input wire pclk,
   input wire presetn,
   input wire frame_start,
   input wire bus_busy,
   input wire [3:0] code,
   output wire expired
);
   reg [CW-1:0] count_r;
   wire [CW-1:0] limit;
   // 0 for code[2:0] of 0, else 2^(code[2:0]-1)
   assign limit = (code[2:0] == 3'h0) ? {CW{1'b0}} :
                  ({{(CW-1){1'b0}}, 1'b1} << (code[2:0] - 3'h1));
   // cycle counter, restarted at each frame assertion
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= {CW{1'b0}};
      end else if (frame_start) begin
         count_r <= {CW{1'b0}};
      end else if (bus_busy && (count_r != {CW{1'b1}})) begin
         count_r <= count_r + {{(CW-1){1'b0}}, 1'b1};
      end
   end
   assign expired = ~code[3] & bus_busy & (count_r >= limit);
endmodule // preempt_timer
`default_nettype wire

// >>> core/serr_cause_bit.v
`timescale 1ns/1ps
`default_nettype none
// one sticky write-one-to-clear cause flag
module serr_cause_bit (
   input wire pclk,
   input wire presetn,
   input wire set_evt,
   input wire clr,
   output reg flag_r
);
   // set wins over a clear in the same cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= 1'b0;
      end else if (set_evt) begin
         flag_r <= 1'b1;
      end else if (clr) begin
         flag_r <= 1'b0;
      end
   end
endmodule // serr_cause_bit
`default_nettype wire

// >>> testbench/bridge_ctl_props.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of register effects, error reporting and clock gating
module bridge_ctl_props #(parameter NREQ = 4) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic serr_enable,
   input wire logic [7:0] serr_event,
   input wire logic primary_system_error_n,
   input wire logic [4:0] slot_clock_output,
   input wire logic sec_clock_stopped_r,
   input wire logic sec_clock_stop_control_en,
   input wire logic pri_stop_req,
   input wire logic sec_bus_idle,
   input wire logic posted_write_limit_two,
   input wire logic read_flow_through_en,
   input wire logic [NREQ-1:0] sec_gnt_r,
   input wire logic bridge_gnt_r
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // access phase of an apb write transfer
   wire wr_acc = psel && penable && pwrite;
   limit_two_a: assert property (wr_acc && paddr == 12'h040 && pstrb[1] |=>
      posted_write_limit_two == $past(pwdata[12])) else $error("write limit wrong");
   flow_enable_a: assert property (wr_acc && paddr == 12'h048 && pstrb[0] |=>
      read_flow_through_en == $past(pwdata[0])) else $error("flow enable wrong");
   error_cause_a: assert property ($fell(primary_system_error_n) |->
      $past(serr_enable) && $past(serr_event) != 8'h00) else $error("error without cause");
   timeout_error_a: assert property (serr_enable && serr_event[7] |=>
      !primary_system_error_n) else $error("timeout error missing");
   slot_off_a: assert property (wr_acc && paddr == 12'h068 && pstrb[0] &&
      pwdata[1:0] == 2'b11 |=> ##1 !slot_clock_output[0]) else $error("slot clock running");
   no_stop_a: assert property (!(sec_clock_stop_control_en && (pri_stop_req || sec_bus_idle)) |=>
      !sec_clock_stopped_r) else $error("clock stopped wrongly");
   stop_gates_a: assert property (sec_clock_stopped_r [*2] |->
      slot_clock_output == 5'h00) else $error("slots run while stopped");
   unmapped_read_a: assert property (psel && penable && !pwrite && paddr == 12'h050 |->
      pslverr && prdata == 32'h0000_0000) else $error("unmapped read wrong");
   one_grant_a: assert property ($onehot0({sec_gnt_r, bridge_gnt_r}))
      else $error("several grants");
   cover property ($fell(primary_system_error_n));
   cover property ($rose(sec_clock_stopped_r));
   cover property ($rose(bridge_gnt_r));
endmodule // bridge_ctl_props
`default_nettype wire

// >>> testbench/bridge_device_specific_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module bridge_device_specific_control_test;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic serr_enable = 1'b0, pri_stop_req = 1'b0, err_low;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rd;
   logic [3:0] pstrb = 4'h0;
   logic [7:0] serr_event = 8'h00;
   logic [4:0] want = 5'h00;
   wire logic [31:0] prdata;
   wire logic [3:0] sec_gnt_r, sec_req;
   wire logic [4:0] slot_clock_output, first_r;
   wire logic pready, pslverr, bridge_gnt_r, primary_system_error_n, sec_clock_stopped_r;
   wire logic pri_clock_run_req, sec_clock_stop_control_en, pri_clock_stop_control_en, posted_write_limit_two;
   wire logic read_flow_through_en, down_prefetch_dyn_en, up_prefetch_dyn_en;
   wire logic read_wait_cache_line, bridge_req, sec_frame, sec_bus_idle;
   int n_fail = 0, checks_done = 0;
   bridge_device_specific_control #(.NREQ(4)) DUT (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .serr_enable,
      .serr_event, .sec_req, .bridge_req, .sec_frame, .sec_bus_idle, .pri_stop_req,
      .sec_gnt_r, .bridge_gnt_r, .primary_system_error_n, .slot_clock_output,
      .sec_clock_stopped_r, .pri_clock_run_req, .sec_clock_stop_control_en, .pri_clock_stop_control_en,
      .posted_write_limit_two, .read_flow_through_en, .down_prefetch_dyn_en,
      .up_prefetch_dyn_en, .read_wait_cache_line);
   sec_bus_masters masters (.pclk, .presetn, .sec_gnt_r, .bridge_gnt_r, .want, .sec_req,
      .bridge_req, .sec_frame, .sec_bus_idle, .first_r);
   always #2 pclk = ~pclk;
   // one apb transfer: setup, access until pready, then release
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) n_fail++;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000, 4'h0);
      `CHK($sformatf("reg %h", a), e, rd)
   endtask
   // one-cycle event pulse, error level sampled after it lands
   task automatic pulse(input logic [7:0] e);
      serr_event <= e;
      @(posedge pclk);
      serr_event <= 8'h00;
      #1 err_low = !primary_system_error_n;
      @(posedge pclk);
   endtask
   task automatic idle_wait;
      int n;
      n = 0;
      @(posedge pclk);
      while (sec_bus_idle !== 1'b1 && n < 200) begin @(posedge pclk); n++; end
      if (n == 200) n_fail++;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #100000;
      n_fail++;
      conclude;
   end
   // main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(12'h040, 32'h0200_0000);
      rc(12'h048, 32'h0000_0000);
      rc(12'h068, 32'h0000_3E00);
      rc(12'h06C, 32'h0000_0000);
      `CHK("prefetch", 2'b11, {down_prefetch_dyn_en, up_prefetch_dyn_en})
      $display("test reset done");
      wr(12'h040, 32'hFFFF_FFFF);
      rc(12'h040, 32'h020F_1000);
      `CHK("limit", 1'b1, posted_write_limit_two)
      wr(12'h048, 32'hFFFF_FFFF);
      rc(12'h048, 32'h0000_001F);
      `CHK("opts", 4'b1001, {read_flow_through_en, down_prefetch_dyn_en, up_prefetch_dyn_en, read_wait_cache_line})
      wr(12'h04C, 32'hFFFF_FFFF);
      rc(12'h04C, 32'hF000_0000);
      rc(12'h050, 32'h0000_0000);
      wr(12'h068, 32'hFFFF_FFFF);
      rc(12'h068, 32'h0000_3FFF);
      for (int c = 0; c < 4; c++) begin
         wr(12'h068, {23'h0, c[1] & c[0], {4{c[1:0]}}});
         @(posedge pclk);
         `CHK("slots", (c == 3) ? 5'h00 : 5'h1F, slot_clock_output)
      end
      wr(12'h068, 32'h0000_0000);
      $display("test registers done");
      serr_enable <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i);
         `CHK("error low", 1'b1, err_low)
         rc(12'h068, 32'h0000_3E00 | (32'h0001_0000 << i));
         apb(1'b1, 12'h068, 32'h00FF_0000, 4'h4);
         rc(12'h068, 32'h0000_3E00);
      end
      wr(12'h064, 32'hFFFF_FFFF);
      rc(12'h064, 32'h0000_007E);
      pulse(8'h64);
      `CHK("masked", 1'b0, err_low)
      pulse(8'hFF);
      rc(12'h068, 32'h0081_3E00);
      apb(1'b1, 12'h068, 32'h00FF_0000, 4'h4);
      wr(12'h064, 32'h0000_0000);
      serr_enable <= 1'b0;
      pulse(8'hFF);
      `CHK("error high", 1'b0, err_low)
      rc(12'h068, 32'h0000_3E00);
      $display("test errors done");
      // mid-run reset clears options and parked grants before arbitration
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(12'h048, 32'h0000_0000);
      wr(12'h040, 32'h0200_0000);
      want <= 5'h11;
      idle_wait;
      `CHK("owner", 5'h10, first_r)
      want <= 5'h00;
      wr(12'h040, 32'h0002_0000);
      want <= 5'h12;
      idle_wait;
      `CHK("owner", 5'h02, first_r)
      want <= 5'h04;
      idle_wait;
      `CHK("park last", 4'h4, sec_gnt_r)
      want <= 5'h00;
      wr(12'h048, 32'h0000_0002);
      repeat (2) @(posedge pclk);
      `CHK("park", 5'h10, {bridge_gnt_r, sec_gnt_r})
      $display("test arbiter done");
      wr(12'h06C, 32'h1200_0000);
      repeat (3) @(posedge pclk);
      rc(12'h06C, 32'h1300_0000);
      `CHK("stopped slots", 5'h00, slot_clock_output)
      pri_stop_req <= 1'b1;
      wr(12'h06C, 32'h0E00_0000);
      `CHK("clock_stop_control", 3'b111, {pri_clock_run_req, sec_clock_stop_control_en, pri_clock_stop_control_en})
      wr(12'h06C, 32'h1200_0000);
      rc(12'h06C, 32'h1200_0000);
      $display("test clock_stop_control done");
      conclude;
   end
endmodule // bridge_device_specific_control_test
bind bridge_device_specific_control bridge_ctl_props #(.NREQ(NREQ)) props (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .serr_enable,
   .serr_event, .primary_system_error_n, .slot_clock_output, .sec_clock_stopped_r,
   .sec_clock_stop_control_en, .pri_stop_req, .sec_bus_idle, .posted_write_limit_two,
   .read_flow_through_en, .sec_gnt_r, .bridge_gnt_r);
`default_nettype wire

// >>> testbench/sec_bus_masters.sv
`timescale 1ns/1ps
`default_nettype none
// secondary masters: each runs one four-cycle frame per grant
module sec_bus_masters (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] sec_gnt_r,
   input wire logic bridge_gnt_r,
   input wire logic [4:0] want,
   output logic [3:0] sec_req,
   output logic bridge_req,
   output var logic sec_frame,
   output logic sec_bus_idle,
   output var logic [4:0] first_r
);
   logic [4:0] done_r;
   logic [4:0] g;
   logic [2:0] cnt_r;
   // a master requests until served once
   assign {bridge_req, sec_req} = want & ~done_r;
   assign sec_bus_idle = !sec_frame && {bridge_req, sec_req} == 5'h00;
   assign g = {bridge_gnt_r, sec_gnt_r} & {bridge_req, sec_req};
   // frame starts the edge after a grant and records the first owner
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_frame <= 1'b0;
         cnt_r <= 3'h0;
         done_r <= 5'h00;
         first_r <= 5'h00;
      end else if (want == 5'h00) begin
         done_r <= 5'h00;
         first_r <= 5'h00;
      end else if (sec_frame) begin
         cnt_r <= cnt_r - 3'h1;
         sec_frame <= cnt_r != 3'h1;
      end else if (g != 5'h00) begin
         sec_frame <= 1'b1;
         cnt_r <= 3'h4;
         done_r <= done_r | g;
         if (first_r == 5'h00) first_r <= g;
      end
   end
endmodule // sec_bus_masters
`default_nettype wire
